/* File: hdl/pin_drive_cell.sv */
// Decode of one pin's setting into driver and pull enables.
`timescale 1ns/1ps

module pin_drive_cell
  import pin_cfg_pkg::*;
(
  // Setting and mode
  input  wire logic cfg_high,
  input  wire logic cfg_low,
  input  wire logic direction,
  input  wire logic data_bit,
  // Pad controls
  output logic      drive_high,
  output logic      drive_low,
  output logic      pull_up,
  output logic      pull_down
);

  logic [1:0] setting;

  assign setting = {cfg_high, cfg_low};

  always_comb
  begin
    drive_high = 1'b0;
    drive_low  = 1'b0;
    pull_up    = 1'b0;
    pull_down  = 1'b0;
    if (direction == DIR_OUTPUT) // [RULE_08]
    begin
      case (setting)
        CFG_HIZ:
        begin
          drive_high = 1'b0; // [RULE_01]
          drive_low  = 1'b0; // [RULE_01]
        end
        CFG_PCH_OD:
          drive_high = data_bit; // [RULE_02] [RULE_10]
        CFG_NCH_OD:
          drive_low  = ~data_bit; // [RULE_03] [RULE_10]
        CFG_PUSH_PULL:
        begin
          drive_high = data_bit; // [RULE_04] [RULE_10]
          drive_low  = ~data_bit; // [RULE_04]
        end
        default:
        begin
          drive_high = 1'b0;
          drive_low  = 1'b0;
        end
      endcase
    end
    else
    begin
      // Drivers stay off in every input setting, so data writes never reach
      // the pad while the pin listens
      case (setting)
        CFG_PCH_OD:
          pull_down = 1'b1; // [RULE_06]
        CFG_NCH_OD:
          pull_up   = 1'b1; // [RULE_07]
        CFG_HIZ,
        CFG_PUSH_PULL:
        begin
          pull_up   = 1'b0; // [RULE_05]
          pull_down = 1'b0; // [RULE_05]
        end
        default:
        begin
          pull_up   = 1'b0;
          pull_down = 1'b0;
        end
      endcase
    end
  end

endmodule // pin_drive_cell

/* File: hdl/port_pin_drive_config.sv */
// Pin drive and bias configuration with an APB register slave.
//
// Notes on behaviour
// RULE_01 - Output mode, setting 00: both high and low drivers off.
// RULE_02 - Output mode, setting 01: drive high on data 1, else undriven.
// RULE_03 - Output mode, setting 10: drive low on data 0, else undriven.
// RULE_04 - Output mode, setting 11: push-pull, high for 1, low for 0.
// RULE_05 - Input mode, settings 00 and 11: no pull, no driver.
// RULE_06 - Input mode, setting 01: pull-down on, drivers off.
// RULE_07 - Input mode, setting 10: pull-up on, drivers off.
// RULE_08 - Direction 0 picks output meanings, direction 1 input meanings.
// RULE_09 - Reset clears both setting registers, pins start high-impedance.
// RULE_10 - Output pin level follows its data bit through the drive type.
// RULE_11 - Data read in input mode returns the sampled pin level.
// RULE_12 - Low register takes byte access and halfword access with high.
// RULE_13 - High register takes byte reads and writes, resets to zero.
// RULE_14 - Pin n uses bit n of high and bit n of low register.
// RULE_15 - Pin count is a build parameter; absent pins have no bits.
// RULE_16 - Data writes in input mode are kept but leave pin unchanged.
// RULE_17 - Writes land at bus completion edge; pads update next cycle.
// RULE_18 - High register bit 7 reads zero and ignores writes.
`timescale 1ns/1ps

module port_pin_drive_config
  import pin_cfg_pkg::*;
#(
  parameter int PIN_COUNT = PIN_COUNT_DEFAULT
)
(
  // Clock, reset and enable
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [APB_ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Data and direction registers held elsewhere
  input  wire logic [PIN_COUNT-1:0]      pin_level_reg,
  input  wire logic [PIN_COUNT-1:0]      pin_direction_reg,
  // Value seen when the data register is read
  output logic [PIN_COUNT-1:0]           pin_level_read,
  // Pads
  input  wire logic [PIN_COUNT-1:0]      pad_in,
  output logic [PIN_COUNT-1:0]           pad_out,
  output logic [PIN_COUNT-1:0]           pad_oe_n,
  output logic [PIN_COUNT-1:0]           pad_pull_up,
  output logic [PIN_COUNT-1:0]           pad_pull_down
);

  // Setting registers, one bit per implemented pin only
  logic [PIN_COUNT-1:0] pin_cfg_low_bits;
  logic [PIN_COUNT-1:0] pin_cfg_high_bits;
  logic [PIN_COUNT-1:0] next_pin_cfg_low_bits;
  logic [PIN_COUNT-1:0] next_pin_cfg_high_bits;

  // Bus state
  logic                 next_pready;
  logic [31:0]          next_prdata;
  logic                 next_pslverr;

  // Pad state
  logic [PIN_COUNT-1:0] next_pad_out;
  logic [PIN_COUNT-1:0] next_pad_oe_n;
  logic [PIN_COUNT-1:0] next_pad_pull_up;
  logic [PIN_COUNT-1:0] next_pad_pull_down;
  logic [PIN_COUNT-1:0] next_pin_level_read;

  // Decoded cell outputs
  logic [PIN_COUNT-1:0] cell_drive_high;
  logic [PIN_COUNT-1:0] cell_drive_low;
  logic [PIN_COUNT-1:0] cell_pull_up;
  logic [PIN_COUNT-1:0] cell_pull_down;

  // Bus decode
  logic                 access_wait;
  logic                 access_done;
  logic                 sel_low;
  logic                 sel_high;
  logic [7:0]           low_byte;
  logic [7:0]           high_byte;
  logic [PIN_COUNT-1:0] wdata_low;
  logic [PIN_COUNT-1:0] wdata_high;

  // One wait state lets prdata and pready leave flip-flops directly
  assign access_wait = psel & penable & ~pready;
  assign access_done = psel & penable & pready;
  assign sel_low     = (paddr == CFG_LOW_ADDR);
  assign sel_high    = (paddr == CFG_HIGH_ADDR);

  // Absent pins and bit 7 have no storage and read as zero
  assign low_byte    = 8'(pin_cfg_low_bits);  // [RULE_15]
  assign high_byte   = 8'(pin_cfg_high_bits); // [RULE_18]
  assign wdata_low   = pwdata[PIN_COUNT-1:0];
  assign wdata_high  = pwdata[PIN_COUNT+7:8];

  // Bus answer
  always_comb
  begin
    next_pready  = access_wait;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (access_wait)
    begin
      next_prdata = RDATA_RESET;
      if (sel_low)
      begin
        // Halfword view: low register in lane 0, high register in lane 1
        next_prdata = {16'h0000, high_byte, low_byte}; // [RULE_12]
      end
      else if (sel_high)
      begin
        next_prdata = {24'h000000, high_byte}; // [RULE_13]
      end
      else
      begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= RDATA_RESET;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Setting registers
  always_comb
  begin
    next_pin_cfg_low_bits  = pin_cfg_low_bits;
    next_pin_cfg_high_bits = pin_cfg_high_bits;
    if (access_done && pwrite) // [RULE_17]
    begin
      if (sel_low)
      begin
        if (pstrb[LANE_LOW])
        begin
          next_pin_cfg_low_bits = wdata_low; // [RULE_12] [RULE_14]
        end
        if (pstrb[LANE_HIGH])
        begin
          next_pin_cfg_high_bits = wdata_high; // [RULE_12] [RULE_14]
        end
      end
      else if (sel_high && pstrb[LANE_LOW])
      begin
        // Bit 7 is never stored
        next_pin_cfg_high_bits = wdata_low; // [RULE_13] [RULE_18]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_cfg_low_bits  <= CFG_LOW_RESET[PIN_COUNT-1:0];  // [RULE_09]
      pin_cfg_high_bits <= CFG_HIGH_RESET[PIN_COUNT-1:0]; // [RULE_09]
    end
    else if (clk_en)
    begin
      pin_cfg_low_bits  <= next_pin_cfg_low_bits;
      pin_cfg_high_bits <= next_pin_cfg_high_bits;
    end
  end

  // Per-pin decode
  generate
    for (genvar n = 0; n < PIN_COUNT; n++)
    begin : g_pin
      pin_drive_cell u_cell (
        .cfg_high   (pin_cfg_high_bits[n]), // [RULE_14]
        .cfg_low    (pin_cfg_low_bits[n]),  // [RULE_14]
        .direction  (pin_direction_reg[n]),
        .data_bit   (pin_level_reg[n]),
        .drive_high (cell_drive_high[n]),
        .drive_low  (cell_drive_low[n]),
        .pull_up    (cell_pull_up[n]),
        .pull_down  (cell_pull_down[n])
      );
    end
  endgenerate

  // Pad controls; the register stage costs one cycle of latency but keeps
  // the pads glitch free while settings and data change together
  always_comb
  begin
    next_pad_out       = cell_drive_high;
    next_pad_oe_n      = ~(cell_drive_high | cell_drive_low); // [RULE_01]
    next_pad_pull_up   = cell_pull_up;
    next_pad_pull_down = cell_pull_down;
    // Input pins report the pad; output pins report the stored data
    next_pin_level_read = pin_level_reg;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (pin_direction_reg[i] == DIR_INPUT)
      begin
        next_pin_level_read[i] = pad_in[i]; // [RULE_11] [RULE_16]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out        <= '0;
      pad_oe_n       <= '1;
      pad_pull_up    <= '0;
      pad_pull_down  <= '0;
      pin_level_read <= '0;
    end
    else if (clk_en)
    begin
      pad_out        <= next_pad_out;       // [RULE_17]
      pad_oe_n       <= next_pad_oe_n;      // [RULE_17]
      pad_pull_up    <= next_pad_pull_up;   // [RULE_17]
      pad_pull_down  <= next_pad_pull_down; // [RULE_17]
      pin_level_read <= next_pin_level_read;
    end
  end

endmodule // port_pin_drive_config

/* File: include/pin_cfg_pkg.sv */
// Constants shared by the pin drive configuration block.
package pin_cfg_pkg;

  // Number of implemented pins by default; legal builds are 3, 4 or 7
  localparam int          PIN_COUNT_DEFAULT = 7;
  localparam int          PIN_COUNT_MAX     = 7;

  // Register indices as printed; the byte address is four times the index
  localparam logic [17:0] CFG_LOW_INDEX     = 18'h0F24A;
  localparam logic [17:0] CFG_HIGH_INDEX    = 18'h0F24B;
  localparam logic [19:0] CFG_LOW_ADDR      = {CFG_LOW_INDEX, 2'b00};
  localparam logic [19:0] CFG_HIGH_ADDR     = {CFG_HIGH_INDEX, 2'b00};
  localparam int          APB_ADDR_WIDTH    = 20;

  // Byte lanes of the bus word
  localparam int          LANE_LOW          = 0;
  localparam int          LANE_HIGH         = 1;

  // Reset values
  localparam logic [7:0]  CFG_LOW_RESET     = 8'h00;
  localparam logic [7:0]  CFG_HIGH_RESET    = 8'h00;
  localparam logic [31:0] RDATA_RESET       = 32'h00000000;

  // Direction bit meaning
  localparam logic        DIR_OUTPUT        = 1'b0;
  localparam logic        DIR_INPUT         = 1'b1;

  // Two-bit setting, upper bit first
  localparam logic [1:0]  CFG_HIZ           = 2'b00;
  localparam logic [1:0]  CFG_PCH_OD        = 2'b01;
  localparam logic [1:0]  CFG_NCH_OD        = 2'b10;
  localparam logic [1:0]  CFG_PUSH_PULL     = 2'b11;

endpackage : pin_cfg_pkg

/* File: tb/pin_board_model.sv */
// Board model: external drivers and resistors seen on the pads.
`timescale 1ns/1ps
module pin_board_model #(parameter int N = 7)
(
  // Clock and pad controls
  input  logic         pclk,
  input  logic [N-1:0] pad_out,
  input  logic [N-1:0] pad_oe_n,
  input  logic [N-1:0] pad_pull_up,
  input  logic [N-1:0] pad_pull_down,
  // Board drivers and sensed level
  input  logic [N-1:0] ext_en,
  input  logic [N-1:0] ext_val,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] drift = '0;
  // A floating pin toggles so a stale level is never trusted
  always @(posedge pclk) drift <= ~drift;
  always_comb
    for (int i = 0; i < N; i++)
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = drift[i];
endmodule // pin_board_model

/* File: tb/pin_cfg_monitor.sv */
// Port-level checks for the pin drive configuration block.
`timescale 1ns/1ps
module pin_cfg_monitor #(parameter int PIN_COUNT = 7)
(
  // Clock, reset, enable and bus handshake
  input logic                 pclk,
  input logic                 presetn,
  input logic                 clk_en,
  input logic                 psel,
  input logic                 penable,
  input logic                 pready,
  input logic                 pslverr,
  input logic [31:0]          prdata,
  // Data, direction and pads
  input logic [PIN_COUNT-1:0] pin_level_reg,
  input logic [PIN_COUNT-1:0] pin_direction_reg,
  input logic [PIN_COUNT-1:0] pin_level_read,
  input logic [PIN_COUNT-1:0] pad_in,
  input logic [PIN_COUNT-1:0] pad_out,
  input logic [PIN_COUNT-1:0] pad_oe_n,
  input logic [PIN_COUNT-1:0] pad_pull_up,
  input logic [PIN_COUNT-1:0] pad_pull_down
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The driven-level check skips the edge after reset or after a frozen cycle, and
  // the input-mode check only the edge after reset, when the pads hold an older decode
  wait_state_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("no answer after access cycle");
  one_cycle_a: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");
  err_resp_a: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  in_mode_a: assert property (
    $past(presetn) |->
      (pad_oe_n & $past(pin_direction_reg)) == $past(pin_direction_reg))
    else $error("input pin driven");
  out_mode_a: assert property (
    ((pad_pull_up | pad_pull_down) & ~$past(pin_direction_reg)) == '0)
    else $error("pull on in output mode");
  pull_excl_a: assert property (
    (pad_pull_up & pad_pull_down) == '0)
    else $error("both pulls on");
  drive_val_a: assert property (
    $past(presetn) && $past(clk_en) |->
      ((pad_out ^ $past(pin_level_reg)) & ~pad_oe_n) == '0)
    else $error("driven level differs from data");
  read_val_a: assert property (
    $past(presetn) && $past(clk_en) |->
      pin_level_read == ($past(pad_in) & $past(pin_direction_reg) |
                         $past(pin_level_reg) & ~$past(pin_direction_reg)))
    else $error("level read wrong");
endmodule // pin_cfg_monitor

bind port_pin_drive_config pin_cfg_monitor #(.PIN_COUNT(PIN_COUNT))
  pin_cfg_monitor_i (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the pin drive configuration block.
`timescale 1ns/1ps
module tb_top
  import pin_cfg_pkg::*;
;
  localparam int N = 7;
  logic         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         pready, pslverr;
  logic [19:0]  paddr = 20'h0;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic [3:0]   pstrb = 4'h0;
  logic [N-1:0] lvl = '0, dir = '0, een = '0, evl = '0;
  logic [N-1:0] lvl_rd, pad_in, pad_out, oe_n, pu, pd;
  int           n_errors = 0, samples_checked = 0;

  always #12.5 pclk = ~pclk;

  port_pin_drive_config #(.PIN_COUNT(N)) port_pin_drive_config_i (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .pin_level_reg(lvl),
    .pin_direction_reg(dir), .pin_level_read(lvl_rd), .pad_in, .pad_out,
    .pad_oe_n(oe_n), .pad_pull_up(pu), .pad_pull_down(pd));

  pin_board_model #(.N(N)) pin_board_model_i (
    .pclk, .pad_out, .pad_oe_n(oe_n), .pad_pull_up(pu),
    .pad_pull_down(pd), .ext_en(een), .ext_val(evl), .pad_in);

  task automatic end_sim();
    $display("Mismatches %0d in %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic apb(logic w, logic [19:0] a, logic [31:0] d,
                     logic [3:0] s, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk("pready", 32'h1, 32'h0);
      end_sim();
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk("pad_oe_n", {N{1'b1}}, oe_n);
    chk("pulls", 32'h0, pu | pd);
    apb(1'b0, CFG_LOW_ADDR, 32'h0, 4'h0, r, e);
    chk("cfg word", 32'h0, r);
    chk("pslverr", 32'h0, e);
    apb(1'b1, CFG_HIGH_ADDR, 32'h000000FF, 4'h1, r, e);
    apb(1'b0, CFG_HIGH_ADDR, 32'h0, 4'h0, r, e);
    chk("cfg high", 32'h0000007F, r);
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 20'h00010, 32'h0000FFFF, 4'h3, r, e);
    chk("pslverr", 32'h1, e);
    apb(1'b0, 20'h00010, 32'h0, 4'h0, r, e);
    chk("prdata", 32'h0, r);
    apb(1'b0, CFG_LOW_ADDR, 32'h0, 4'h0, r, e);
    chk("cfg word", 32'h00007F00, r);
  endtask

  task automatic t_decode();
    logic [31:0]  r;
    logic         e;
    logic [7:0]   lo, hi;
    logic [1:0]   c2;
    logic [N-1:0] x_oe, x_pu, x_pd, x_rd, known;
    for (int c = 1; c < 33; c++)
    begin
      lo = 8'(c * 37);
      hi = 8'(c * 91);
      @(posedge pclk);
      dir <= N'(c * 13);
      lvl <= N'(c * 7);
      een <= N'(c * 5);
      evl <= N'(c * 11);
      if (c % 2 == 1)
        apb(1'b1, CFG_LOW_ADDR, {16'h0, hi, lo}, 4'h3, r, e);
      else
      begin
        apb(1'b1, CFG_LOW_ADDR, {24'h0, lo}, 4'h1, r, e);
        apb(1'b1, CFG_HIGH_ADDR, {24'h0, hi}, 4'h1, r, e);
      end
      apb(1'b0, CFG_LOW_ADDR, 32'h0, 4'h0, r, e);
      #1;
      chk("cfg", {16'h0, hi & 8'h7F, lo & 8'h7F}, r);
      for (int i = 0; i < N; i++)
      begin
        c2 = {hi[i], lo[i]};
        x_oe[i] = dir[i] || c2 == CFG_HIZ || (c2 == CFG_PCH_OD && !lvl[i])
                  || (c2 == CFG_NCH_OD && lvl[i]);
        x_pu[i] = dir[i] && c2 == CFG_NCH_OD;
        x_pd[i] = dir[i] && c2 == CFG_PCH_OD;
        x_rd[i] = dir[i] ? (een[i] ? evl[i] : x_pu[i]) : lvl[i];
        known[i] = !dir[i] || een[i] || x_pu[i] || x_pd[i];
      end
      chk("pad_oe_n", x_oe, oe_n);
      chk("pad_out", lvl & ~x_oe, pad_out & ~x_oe);
      chk("pull_up", x_pu, pu);
      chk("pull_down", x_pd, pd);
      chk("level_read", x_rd & known, lvl_rd & known);
    end
  endtask

  task automatic t_freeze();
    logic [31:0] r;
    logic        e;
    @(posedge pclk);
    dir <= '0;
    lvl <= '0;
    apb(1'b1, CFG_LOW_ADDR, 32'h00007F7F, 4'h3, r, e);
    repeat (2) @(posedge pclk);
    #1;
    chk("pad_oe_n", 32'h0, oe_n);
    chk("pad_out", 32'h0, pad_out);
    @(posedge pclk);
    clk_en <= 1'b0;
    lvl <= '1;
    repeat (3) @(posedge pclk);
    #1;
    chk("frozen pad_out", 32'h0, pad_out);
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("pad_out", {N{1'b1}}, pad_out);
  endtask

  task automatic t_midreset();
    logic [31:0] r;
    logic        e;
    @(posedge pclk);
    dir <= '1;
    apb(1'b1, CFG_LOW_ADDR, 32'h00007F00, 4'h3, r, e);
    repeat (2) @(posedge pclk);
    #1;
    chk("pull_up", {N{1'b1}}, pu);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk("pull_up", 32'h0, pu);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("pad_oe_n", {N{1'b1}}, oe_n);
    chk("pulls", 32'h0, pu | pd);
    apb(1'b0, CFG_LOW_ADDR, 32'h0, 4'h0, r, e);
    chk("cfg word", 32'h0, r);
  endtask

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_reset();
    t_unmapped();
    t_decode();
    t_freeze();
    t_midreset();
    end_sim();
  end
endmodule // tb_top
